// ===== rtl/tpwm_timer.sv
// dual-slope pwm timer with ahb-lite register access
// What this block does
// R1 - modes 8 and 9 run dual-slope pwm
// R2 - count zero up to top, back down
// R3 - clear on up match, set on down
// R4 - top from capture (8) or compare a (9)
// R5 - top spans 0x0003 up to 16-bit max
// R6 - counter holds top for one tick
// R7 - match flag when counter equals compare
// R8 - overflow flag with buffer load at bottom
// R9 - top reached sets compare-a or capture flag
// R10 - software keeps top at least every compare
// R11 - bottom-only updates give symmetric slopes
// R12 - mode two non-inverted, three inverted
// R13 - pin driven only when direction bit set
// R14 - compare at bottom/top gives steady level
// R15 - period is two times divider times top
// R16 - divider 1, 8, 64, 256 or 1024
// R17 - synchronous, single-cycle tick enable
// R18 - control a layout, read/write, reset zero
// R19 - mode one toggles a when top bit set
// R20 - compare writes buffered until bottom
module tpwm_timer (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic                      hreadyout,
  output logic [31:0]               hrdata,
  output logic                      hresp,
  output tpwm_pkg::tpwm_pins_s      compare_output
);
  tpwm_pkg::tpwm_state_s s_q;
  tpwm_pkg::tpwm_state_s s_d;
  logic [3:0]  waveform_mode_select;
  logic [15:0] top;
  logic        pfc;
  logic        cnt_wr;
  logic [10:0] div;

  // prescaler divider per clock select; zero stops the timer
  function automatic logic [10:0] pre_div(input logic [2:0] cs);
    case (cs)
      3'h1:    pre_div = 11'h001;
      3'h2:    pre_div = 11'h008;
      3'h3:    pre_div = 11'h040;
      3'h4:    pre_div = 11'h100;
      3'h5:    pre_div = 11'h400;
      default: pre_div = 11'h000;
    endcase
  endfunction

  function automatic logic [1:0] com_of(input logic [7:0] c, input int ch);
    com_of = c[tpwm_pkg::CTLA_COM_A_LSB - 2*ch +: 2];
  endfunction

  assign waveform_mode_select = {s_q.wgm_hi, s_q.ctl_a[tpwm_pkg::CTLA_WGM_LSB +: 2]};
  assign pfc = (waveform_mode_select == tpwm_pkg::MODE_TOP_CAP) ||
               (waveform_mode_select == tpwm_pkg::MODE_TOP_A); // R1
  assign top = (waveform_mode_select == tpwm_pkg::MODE_TOP_A) ? s_q.act_v[0] : s_q.icr; // R4
  assign cnt_wr = s_q.ap_sel && s_q.ap_wr && (s_q.ap_addr == tpwm_pkg::OFS_CNT);
  assign div = pre_div(s_q.clk_sel); // R16

  always_comb begin
    logic [4:0]  fset;
    logic [4:0]  fclr;
    logic        rise;
    logic [1:0]  com;
    logic [31:0] rd;
    fset = 5'h00;
    fclr = 5'h00;
    rise = 1'b0;
    com  = 2'h0;
    rd   = 32'h0000_0000;
    s_d  = s_q;
    s_d.rdy = 1'b1;
    // prescaler: tick lasts exactly one clock
    s_d.tick = 1'b0; // R17
    if (div == 11'h000) begin
      s_d.pre = 10'h000;
    // >= catches up after a switch to a smaller divider
    end else if ({1'b0, s_q.pre} >= div - 11'h001) begin
      s_d.pre  = 10'h000;
      s_d.tick = 1'b1; // R15
    end else begin
      s_d.pre = s_q.pre + 10'h001;
    end
    // counter only moves in the two dual-slope modes
    if (s_q.tick && pfc) begin
      // at top the slope already counts as falling, at bottom as rising
      rise = (s_q.up && s_q.cnt != top) || s_q.cnt == tpwm_pkg::BOTTOM;
      if (s_q.cnt == tpwm_pkg::BOTTOM) begin
        s_d.act_v = s_q.buf_v; // R11 R20
        fset[tpwm_pkg::FLG_OVF] = 1'b1; // R8
      end
      if (s_q.cnt == top) begin
        if (waveform_mode_select == tpwm_pkg::MODE_TOP_A) begin
          fset[tpwm_pkg::FLG_MA] = 1'b1; // R9
        end else begin
          fset[tpwm_pkg::FLG_CAP] = 1'b1; // R9
        end
      end
      for (int i = 0; i < 3; i++) begin
        com = com_of(s_q.ctl_a, i);
        if (s_q.cnt == s_q.act_v[i]) begin
          fset[tpwm_pkg::FLG_MA + i] = 1'b1; // R7
          case (com)
            tpwm_pkg::COM_TOGGLE: begin
              if (i == 0 && s_q.wgm_hi[1]) begin
                s_d.oc[i] = ~s_q.oc[i]; // R19
              end
            end
            tpwm_pkg::COM_NONINV: s_d.oc[i] = ~rise; // R3 R12 R14
            tpwm_pkg::COM_INV:    s_d.oc[i] = rise;  // R3 R12 R14
            default: ;
          endcase
        end
      end
      // >= recovers when top is lowered below the count
      if (s_q.up) begin
        if (s_q.cnt >= top) begin
          s_d.up  = 1'b0; // R6
          s_d.cnt = s_q.cnt - 16'h0001;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001; // R2
        end
      end else if (s_q.cnt == tpwm_pkg::BOTTOM) begin
        s_d.up  = 1'b1;
        s_d.cnt = s_q.cnt + 16'h0001; // R2
      end else begin
        s_d.cnt = s_q.cnt - 16'h0001; // R2
      end
    end
    // bus data phase: write lands, software count write wins over ticking
    if (s_q.ap_sel && s_q.ap_wr) begin
      case (s_q.ap_addr)
        tpwm_pkg::OFS_CTL_A: s_d.ctl_a = hwdata[7:0]; // R18
        tpwm_pkg::OFS_CTL_B: begin
          s_d.wgm_hi  = hwdata[tpwm_pkg::CTLB_WGM_LSB +: 2];
          s_d.clk_sel = hwdata[tpwm_pkg::CTLB_CS_LSB +: 3];
        end
        tpwm_pkg::OFS_CNT: s_d.cnt = hwdata[15:0];
        tpwm_pkg::OFS_CMP_A, tpwm_pkg::OFS_CMP_B, tpwm_pkg::OFS_CMP_C: begin
          for (int i = 0; i < 3; i++) begin
            if (s_q.ap_addr == tpwm_pkg::OFS_CMP_A + 8'(4 * i)) begin
              s_d.buf_v[i] = hwdata[15:0]; // R20
              if (!pfc) begin
                s_d.act_v[i] = hwdata[15:0];
              end
            end
          end
        end
        tpwm_pkg::OFS_CAP:   s_d.icr = hwdata[15:0]; // R5
        tpwm_pkg::OFS_FLAGS: fclr = hwdata[4:0];
        tpwm_pkg::OFS_DIR:   s_d.ddr = hwdata[2:0];
        default: ;
      endcase
    end
    // a flag raised in the clearing cycle survives
    s_d.flags = (s_q.flags & ~fclr) | fset;
    // address phase; master idles during data phase so no stale read
    s_d.ap_sel  = hsel && hready && htrans[1];
    s_d.ap_wr   = hwrite;
    s_d.ap_addr = haddr[7:0];
    case (haddr[7:0])
      tpwm_pkg::OFS_CTL_A: rd = {24'h000000, s_q.ctl_a};
      tpwm_pkg::OFS_CTL_B: rd = {27'h0000000, s_q.clk_sel, s_q.wgm_hi};
      tpwm_pkg::OFS_CNT:   rd = {16'h0000, s_q.cnt};
      tpwm_pkg::OFS_CMP_A: rd = {16'h0000, s_q.buf_v[0]};
      tpwm_pkg::OFS_CMP_B: rd = {16'h0000, s_q.buf_v[1]};
      tpwm_pkg::OFS_CMP_C: rd = {16'h0000, s_q.buf_v[2]};
      tpwm_pkg::OFS_CAP:   rd = {16'h0000, s_q.icr};
      tpwm_pkg::OFS_FLAGS: rd = {27'h0000000, s_q.flags};
      tpwm_pkg::OFS_DIR:   rd = {29'h00000000, s_q.ddr};
      default:             rd = 32'h0000_0000;
    endcase
    s_d.rdata = (hsel && hready && htrans[1] && !hwrite) ? rd : 32'h0000_0000;
    // pins: channel connected when its mode is non-zero; b and c ignore reserved one
    for (int i = 0; i < 3; i++) begin
      com = com_of(s_q.ctl_a, i);
      s_d.pins.level[i] = s_q.oc[i];
      s_d.pins.oe_n[i]  = ~(s_q.ddr[i] && pfc && (com[1] ||
                          (com == tpwm_pkg::COM_TOGGLE && i == 0 && s_q.wgm_hi[1]))); // R13
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q           <= '0; // R18
      s_q.up        <= 1'b1;
      s_q.rdy       <= 1'b1;
      s_q.pins.oe_n <= 3'h7;
    end else begin
      s_q <= s_d;
    end
  end

  assign hreadyout      = s_q.rdy;
  assign hrdata         = s_q.rdata;
  assign hresp          = s_q.pins.oe_n[0] & ~s_q.pins.oe_n[0];
  assign compare_output = s_q.pins;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence tick_at_top_s;
    s_q.tick && pfc && s_q.up && s_q.cnt == top && !cnt_wr;
  endsequence
  sequence turned_down_s;
    !s_q.up ##0 s_q.cnt == $past(s_q.cnt) - 16'h0001;
  endsequence

  mode_gate_a: assert property (s_q.tick && !pfc && !cnt_wr |=> $stable(s_q.cnt)) // R1
    else $error("counter moved outside dual-slope modes");
  up_step_a: assert property (s_q.tick && pfc && s_q.up && s_q.cnt < top && !cnt_wr
      |=> s_q.cnt == $past(s_q.cnt) + 16'h0001) // R2
    else $error("counter did not step up");
  top_turn_a: assert property (tick_at_top_s |=> turned_down_s) // R6
    else $error("no turn after top");
  match_flag_a: assert property (s_q.tick && pfc && s_q.cnt == s_q.act_v[1]
      |=> s_q.flags[tpwm_pkg::FLG_MA + 1]) // R7
    else $error("match flag b not set");
  bottom_load_a: assert property (s_q.tick && pfc && s_q.cnt == tpwm_pkg::BOTTOM
      |=> s_q.flags[tpwm_pkg::FLG_OVF] && s_q.act_v[2] == $past(s_q.buf_v[2])) // R8
    else $error("overflow and load not together");
  top_flag_a: assert property (s_q.tick && waveform_mode_select == tpwm_pkg::MODE_TOP_CAP
      && s_q.cnt == s_q.icr |=> s_q.flags[tpwm_pkg::FLG_CAP]) // R9
    else $error("capture flag missing at top");
  buffered_cmp_a: assert property (pfc && !(s_q.tick && s_q.cnt == tpwm_pkg::BOTTOM)
      |=> $stable(s_q.act_v)) // R20
    else $error("active compare changed off bottom");
  pin_gate_a: assert property (!s_q.ddr[1] |=> s_q.pins.oe_n[1]) // R13
    else $error("pin driven without direction bit");
  clear_up_a: assert property (s_q.tick && pfc && com_of(s_q.ctl_a, 0) == tpwm_pkg::COM_NONINV
      && s_q.cnt == s_q.act_v[0] && s_q.up && s_q.cnt != top |=> !s_q.oc[0]) // R3
    else $error("output a not cleared on rising match");
  tick_gap_a: assert property (s_q.tick && s_q.clk_sel == 3'h2 && $stable(s_q.clk_sel)
      |=> !s_q.tick [*7]) // R17
    else $error("tick came early for divide by eight");

  sequence bottom_down_s;
    s_q.tick && pfc && !s_q.up && s_q.cnt == tpwm_pkg::BOTTOM && !cnt_wr;
  endsequence
  sequence restart_up_s;
    s_q.up ##0 s_q.cnt == 16'h0001;
  endsequence

  // slopes, turning points and flags
  down_step_a: assert property ( // R2
      s_q.tick && pfc && !s_q.up && s_q.cnt != tpwm_pkg::BOTTOM && !cnt_wr
      |=> s_q.cnt == $past(s_q.cnt) - 16'h0001)
    else $error("counter did not step down");
  bottom_turn_a: assert property (bottom_down_s |=> restart_up_s) // R2
    else $error("no turn after bottom");
  cap_turn_a: assert property ( // R4
      s_q.tick && waveform_mode_select == tpwm_pkg::MODE_TOP_CAP && s_q.up
      && s_q.cnt == s_q.icr |=> !s_q.up)
    else $error("no turn at capture top");
  a_turn_a: assert property ( // R4
      s_q.tick && waveform_mode_select == tpwm_pkg::MODE_TOP_A && s_q.up
      && s_q.cnt == s_q.act_v[0] |=> !s_q.up)
    else $error("no turn at compare a top");
  top_a_flag_a: assert property ( // R9
      s_q.tick && waveform_mode_select == tpwm_pkg::MODE_TOP_A
      && s_q.cnt == s_q.act_v[0] |=> s_q.flags[tpwm_pkg::FLG_MA])
    else $error("compare a flag missing at top");
  match_c_a: assert property ( // R7
      s_q.tick && pfc && s_q.cnt == s_q.act_v[2]
      |=> s_q.flags[tpwm_pkg::FLG_MA + 2])
    else $error("match flag c not set");

  // output levels and pin drive
  set_down_a: assert property ( // R3
      s_q.tick && pfc && com_of(s_q.ctl_a, 1) == tpwm_pkg::COM_NONINV && !s_q.up
      && s_q.cnt == s_q.act_v[1] && s_q.cnt != tpwm_pkg::BOTTOM |=> s_q.oc[1])
    else $error("output b not set on falling match");
  inv_up_a: assert property ( // R12
      s_q.tick && pfc && com_of(s_q.ctl_a, 1) == tpwm_pkg::COM_INV && s_q.up
      && s_q.cnt == s_q.act_v[1] && s_q.cnt != top |=> s_q.oc[1])
    else $error("inverted output b not set on rising match");
  bottom_low_a: assert property ( // R14
      s_q.tick && pfc && com_of(s_q.ctl_a, 1) == tpwm_pkg::COM_NONINV
      && s_q.act_v[1] == tpwm_pkg::BOTTOM && s_q.cnt == tpwm_pkg::BOTTOM |=> !s_q.oc[1])
    else $error("output b not low for compare at bottom");
  top_high_a: assert property ( // R14
      s_q.tick && pfc && com_of(s_q.ctl_a, 0) == tpwm_pkg::COM_NONINV && s_q.cnt == top
      && s_q.act_v[0] == top && top != tpwm_pkg::BOTTOM |=> s_q.oc[0])
    else $error("output a not high for compare at top");
  toggle_a_a: assert property ( // R19
      s_q.tick && pfc && s_q.wgm_hi[1] && com_of(s_q.ctl_a, 0) == tpwm_pkg::COM_TOGGLE
      && s_q.cnt == s_q.act_v[0] |=> s_q.oc[0] != $past(s_q.oc[0]))
    else $error("output a did not toggle");
  pin_drive_a: assert property ( // R13
      s_q.ddr[0] && pfc && com_of(s_q.ctl_a, 0) == tpwm_pkg::COM_NONINV |=> !s_q.pins.oe_n[0])
    else $error("pin a not driven");

  // tick spacing; a changed select releases the divide by 64 and 256 checks
  div1_tick_a: assert property (s_q.clk_sel == 3'h1 |=> s_q.tick) // R16
    else $error("no tick every clock for divide by one");
  stopped_a: assert property (s_q.clk_sel == 3'h0 |=> !s_q.tick) // R16
    else $error("tick while timer stopped");
  div64_gap_a: assert property ( // R16
      s_q.tick && s_q.clk_sel == 3'h3 |-> ##64 (s_q.tick || s_q.clk_sel != 3'h3))
    else $error("tick spacing wrong for divide by 64");
  div256_gap_a: assert property ( // R16
      s_q.tick && s_q.clk_sel == 3'h4 |-> ##256 (s_q.tick || s_q.clk_sel != 3'h4))
    else $error("tick spacing wrong for divide by 256");

  // register bus
  ctl_write_a: assert property ( // R18
      s_q.ap_sel && s_q.ap_wr && s_q.ap_addr == tpwm_pkg::OFS_CTL_A
      |=> s_q.ctl_a == $past(hwdata[7:0]))
    else $error("control a write did not land");
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus stalled or answered with error");
  read_once_a: assert property (s_q.rdata != 32'h0000_0000 |=> s_q.rdata == 32'h0000_0000)
    else $error("read data stood beyond its data phase");
endmodule

// ===== rtl/tpwm_pkg.sv
// constants and types for the dual-slope pwm timer
package tpwm_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0] OFS_CTL_A  = 8'h00;
  localparam logic [7:0] OFS_CTL_B  = 8'h04;
  localparam logic [7:0] OFS_CNT    = 8'h08;
  localparam logic [7:0] OFS_CMP_A  = 8'h0C;
  localparam logic [7:0] OFS_CMP_B  = 8'h10;
  localparam logic [7:0] OFS_CMP_C  = 8'h14;
  localparam logic [7:0] OFS_CAP    = 8'h18;
  localparam logic [7:0] OFS_FLAGS  = 8'h1C;
  localparam logic [7:0] OFS_DIR    = 8'h20;
  // control b fields: bits 1:0 upper mode bits, bits 4:2 clock select
  localparam int CTLB_WGM_LSB = 0;
  localparam int CTLB_CS_LSB  = 2;
  // control a fields
  localparam int CTLA_COM_A_LSB = 6;
  localparam int CTLA_COM_B_LSB = 4;
  localparam int CTLA_COM_C_LSB = 2;
  localparam int CTLA_WGM_LSB   = 0;
  localparam logic [7:0] CTLA_RST = 8'h00;
  // flag positions
  localparam int FLG_OVF = 0;
  localparam int FLG_CAP = 1;
  localparam int FLG_MA  = 2;
  // mode values and bottom count
  localparam logic [3:0] MODE_TOP_CAP = 4'h8;
  localparam logic [3:0] MODE_TOP_A   = 4'h9;
  localparam logic [1:0] COM_TOGGLE   = 2'h1;
  localparam logic [1:0] COM_NONINV   = 2'h2;
  localparam logic [1:0] COM_INV      = 2'h3;
  localparam logic [15:0] BOTTOM      = 16'h0000;

  typedef struct packed {
    logic [2:0] level;
    logic [2:0] oe_n;
  } tpwm_pins_s;

  typedef struct packed {
    logic [7:0]  ctl_a;
    logic [1:0]  wgm_hi;
    logic [2:0]  clk_sel;
    logic [15:0] cnt;
    logic        up;
    logic [2:0][15:0] buf_v;
    logic [2:0][15:0] act_v;
    logic [15:0] icr;
    logic [4:0]  flags;
    logic [2:0]  ddr;
    logic [2:0]  oc;
    logic [9:0]  pre;
    logic        tick;
    logic        ap_sel;
    logic        ap_wr;
    logic [7:0]  ap_addr;
    logic [31:0] rdata;
    logic        rdy;
    tpwm_pins_s  pins;
  } tpwm_state_s;
endpackage

// ===== verification/tpwm_timer_tb_top.sv
// self-checking bench for the dual-slope pwm timer
module tpwm_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic                 clock;
  logic                 rst_n;
  logic                 hsel;
  logic [31:0]          haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [31:0]          hwdata;
  logic                 hreadyout;
  logic [31:0]          hrdata;
  logic                 hresp;
  tpwm_pkg::tpwm_pins_s compare_output;
  int                   mismatches = 0;
  int                   n_checks = 0;
  logic [31:0]          rd;
  logic [31:0]          rd2;
  int                   per;
  int                   hi;
  int                   divs[5] = '{1, 8, 64, 256, 1024};

  tpwm_timer tpwm_timer_i (
    .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .compare_output(compare_output)
  );

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one single transfer; the wait ends only on hready or the watchdog
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge clock);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {24'h000000, a};
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rdat = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] dummy;
    bus(1'b1, a, wd, dummy);
  endtask

  // period and high time of one pin, sampled away from the launching edge
  task automatic measure(input int ch, output int p, output int h);
    int   guard;
    logic prev;
    p = 0;
    h = 0;
    guard = 0;
    @(negedge clock);
    while (!(compare_output.level[ch] === 1'b0) && guard < 20000) begin
      @(negedge clock);
      guard++;
    end
    while (!(compare_output.level[ch] === 1'b1) && guard < 20000) begin
      @(negedge clock);
      guard++;
    end
    do begin
      prev = compare_output.level[ch];
      @(negedge clock);
      p++;
      if (compare_output.level[ch] === 1'b1) h++;
    end while (!(compare_output.level[ch] === 1'b1 && prev === 1'b0) && p < 20000);
  endtask

  initial begin
    #5000000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    rst_n  = 1'b0;
    hsel   = 1'b0;
    haddr  = 32'h00000000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h00000000;
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    bus(1'b0, tpwm_pkg::OFS_CTL_A, 32'h0, rd);
    check("ctl_a reset", rd, {24'h0, tpwm_pkg::CTLA_RST});
    wr(tpwm_pkg::OFS_CTL_A, 32'h000000FF);
    bus(1'b0, tpwm_pkg::OFS_CTL_A, 32'h0, rd);
    check("ctl_a rw", rd, 32'h000000FF);
    bus(1'b0, 8'h40, 32'h0, rd);
    check("unmapped read", rd, 32'h00000000);
    check("hresp", {31'h0, hresp}, 32'h00000000);
    check("hready", {31'h0, hreadyout}, 32'h00000001);
    // mode 9: top from compare a; a at top, b inverted at 1
    wr(tpwm_pkg::OFS_CMP_A, 32'h00000003);
    wr(tpwm_pkg::OFS_CMP_B, 32'h00000001);
    wr(tpwm_pkg::OFS_DIR, 32'h00000007);
    wr(tpwm_pkg::OFS_CTL_A, 32'h000000B1);
    for (int i = 0; i < 5; i++) begin
      wr(tpwm_pkg::OFS_CTL_B, {27'h0, 3'(i + 1), 2'b10});
      measure(1, per, hi);
      measure(1, per, hi);
      check("period", per, 2 * divs[i] * 3);
      check("inv high", hi, 4 * divs[i]);
    end
    check("a at top", {31'h0, compare_output.level[0]}, 32'h1);
    check("oe", {29'h0, compare_output.oe_n}, 32'h4);
    bus(1'b0, tpwm_pkg::OFS_FLAGS, 32'h0, rd);
    check("flags m9", rd & 32'h0F, 32'h0D);
    wr(tpwm_pkg::OFS_CTL_B, 32'h00000006);
    wr(tpwm_pkg::OFS_CTL_A, 32'h000000A1);
    measure(1, per, hi);
    measure(1, per, hi);
    check("noninv high", hi, 2);
    // mode 8: top from capture register
    wr(tpwm_pkg::OFS_FLAGS, 32'h0000001F);
    wr(tpwm_pkg::OFS_CAP, 32'h00000005);
    wr(tpwm_pkg::OFS_CTL_A, 32'h000000B0);
    measure(1, per, hi);
    measure(1, per, hi);
    check("cap period", per, 10);
    check("cap high", hi, 8);
    bus(1'b0, tpwm_pkg::OFS_FLAGS, 32'h0, rd);
    check("cap flag", {31'h0, rd[tpwm_pkg::FLG_CAP]}, 32'h1);
    // compare at bottom with non-inverted gives a steady low
    wr(tpwm_pkg::OFS_CMP_B, 32'h00000000);
    wr(tpwm_pkg::OFS_CTL_A, 32'h000000A0);
    repeat (20) @(negedge clock);
    hi = 0;
    repeat (30) begin
      @(negedge clock);
      if (compare_output.level[1] !== 1'b0) hi++;
    end
    check("bottom low", hi, 0);
    wr(tpwm_pkg::OFS_DIR, 32'h00000000);
    repeat (2) @(negedge clock);
    check("oe off", {29'h0, compare_output.oe_n}, 32'h7);
    // mode 9 again: a toggles at top, c inverted at 2
    wr(tpwm_pkg::OFS_CMP_C, 32'h00000002);
    wr(tpwm_pkg::OFS_CTL_A, 32'h0000004D);
    measure(2, per, hi);
    measure(2, per, hi);
    check("c period", per, 6);
    check("c inv high", hi, 2);
    measure(0, per, hi);
    measure(0, per, hi);
    check("toggle period", per, 12);
    check("toggle high", hi, 6);
    // mode 11 is not this mode: counter must stand still
    wr(tpwm_pkg::OFS_CTL_A, 32'h000000A3);
    wr(tpwm_pkg::OFS_CNT, 32'h00000002);
    bus(1'b0, tpwm_pkg::OFS_CNT, 32'h0, rd);
    repeat (10) @(posedge clock);
    bus(1'b0, tpwm_pkg::OFS_CNT, 32'h0, rd2);
    check("frozen", rd2, rd);
    check("count held", rd2, 32'h00000002);
    report_and_stop();
  end
endmodule
